// *** mcr_pkg.sv ***
// Shared types, field positions and octet decoders for the multichannel receive path.
// Assumes one system clock; every other clock arrives as a sampled pin.
package mcr_pkg;

   // Buffer geometry: one column per channel, rows indexed by the position marker
   localparam int NUM_COLS = 4;
   localparam int COL_W    = 2;
   localparam int ROW_W    = 6;
   localparam int NUM_ROWS = 64;
   localparam int BLK_W    = 72;
   localparam int XFER_W   = 36;
   localparam int TAG_W    = 16;
   localparam int OCT_N    = 8;
   localparam int OCT_W    = 3;

   // Control characters and MAC-side replacements
   localparam logic [7:0] CH_START    = 8'hFB;
   localparam logic [7:0] CH_PREAMBLE = 8'h55;
   localparam logic [7:0] CH_SFD      = 8'hD5;
   localparam logic [7:0] CH_IDLE     = 8'h07;
   localparam logic [7:0] CH_TERM     = 8'hFD;

   // Half-block shift signatures
   localparam logic [3:0]  MIS_IDLE_CTRL = 4'hF;
   localparam logic [31:0] MIS_IDLE_DATA = 32'h08080808;
   localparam logic [3:0]  MIS_HDR_CTRL  = 4'h8;

   // Header field positions
   localparam logic START_HEADER = 1'b1;
   localparam int   TYPE_BIT     = 16;
   localparam int   POS_LSB      = 40;
   localparam int   TAG_LSB      = 48;

   typedef logic [BLK_W-1:0] mcr_blk_t;
   typedef logic [ROW_W-1:0] mcr_row_t;

   // One xMII transfer, data above control
   typedef struct packed {
      logic [31:0] data;
      logic [3:0]  ctrl;
   } mcr_xfer_t;

   // Buffer write from one receive channel
   typedef struct packed {
      logic     en;
      logic     envStart;
      mcr_row_t row;
      mcr_blk_t blk;
   } mcr_wr_t;

   // Octet towards the MACs
   typedef struct packed {
      logic             strobe;
      logic             valid;
      logic [TAG_W-1:0] tag;
      logic [7:0]       data;
   } mcr_mac_t;

   // Block layout is {second transfer, first transfer}
   function automatic logic blkCtrl(input mcr_blk_t b, input int k);
      blkCtrl = (k < 4) ? b[k] : b[32+k];
   endfunction

   function automatic logic [7:0] blkData(input mcr_blk_t b, input int k);
      blkData = (k < 4) ? b[4+8*k +: 8] : b[8+8*k +: 8];
   endfunction

   function automatic logic header_detect(input mcr_blk_t b);
      header_detect = blkCtrl(b, 0) && (blkData(b, 0) == CH_START);
   endfunction

   function automatic logic half_shift_detect(input mcr_blk_t b);
      half_shift_detect = ((b[39:36] == MIS_IDLE_CTRL) && (b[71:40] == MIS_IDLE_DATA)) ||
                     ((b[39:36] == MIS_HDR_CTRL) && (b[47:40] == CH_START));
   endfunction

   // Header cell is stored as start, preamble and SFD, so the MAC sees seven preamble octets then SFD
   function automatic mcr_blk_t preambleBlock();
      mcr_blk_t b;
      b = '0;
      b[0] = 1'b1;
      b[11:4] = CH_START;
      for (int k = 1; k < OCT_N - 1; k++) begin
         if (k < 4) b[4+8*k +: 8] = CH_PREAMBLE;
         else b[8+8*k +: 8] = CH_PREAMBLE;
      end
      b[71:64] = CH_SFD;
      preambleBlock = b;
   endfunction

endpackage

// *** mcr_rx_channel.sv ***
// One channel receive process: pairs link transfers into blocks, realigns, writes buffer.
// Assumes link clock and data are raw pins; reset is already synchronised to clk_sys.
module mcr_rx_channel
   import mcr_pkg::*;
(
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic             linkClk,
   input  wire mcr_xfer_t        linkXfer,
   output mcr_wr_t               wr_q,
   output logic [TAG_W-1:0]      tag_q,
   output logic                  tagValid_q
);

   logic [2:0]   clkSync_q;
   mcr_xfer_t    xferS1_q, xferS2_q;
   mcr_xfer_t    half_q;
   logic         haveHalf_q;
   mcr_row_t     row_q;
   logic         linkEdge;
   mcr_blk_t     blk;

   // Two-stage sync of pin clock and data; third stage only for edge finding
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         clkSync_q <= '0;
         xferS1_q  <= '0;
         xferS2_q  <= '0;
      end else begin
         clkSync_q <= {clkSync_q[1:0], linkClk};
         xferS1_q  <= linkXfer;
         xferS2_q  <= xferS1_q;
      end
   end

   // Both clock edges carry a transfer
   assign linkEdge = clkSync_q[2] ^ clkSync_q[1];
   assign blk      = {xferS2_q, half_q};

   // Pairing and half-block realignment
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         half_q     <= '0;
         haveHalf_q <= 1'b0;
      end else if (linkEdge) begin
         half_q <= xferS2_q;
         if (!haveHalf_q) haveHalf_q <= 1'b1;
         else if (!half_shift_detect(blk)) haveHalf_q <= 1'b0;
      end
   end

   // Header decode and cyclic row walk; no other error checks are made
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wr_q       <= '0;
         row_q      <= '0;
         tag_q      <= '0;
         tagValid_q <= 1'b0;
      end else begin
         wr_q.en       <= 1'b0;
         wr_q.envStart <= 1'b0;
         if (linkEdge && haveHalf_q && !half_shift_detect(blk)) begin
            if (header_detect(blk)) begin
               wr_q.en       <= 1'b1;
               wr_q.envStart <= (blk[TYPE_BIT] == START_HEADER);
               wr_q.row      <= blk[POS_LSB +: ROW_W];
               wr_q.blk      <= preambleBlock();
               row_q         <= blk[POS_LSB +: ROW_W] + 1'b1;
               tag_q         <= blk[TAG_LSB +: TAG_W];
               tagValid_q    <= 1'b1;
            end else if (tagValid_q) begin
               wr_q.en  <= 1'b1;
               wr_q.row <= row_q;
               wr_q.blk <= blk;
               row_q    <= row_q + 1'b1;
            end
         end
      end
   end

   a_misalign_drop : assert property (@(posedge clk_sys) disable iff (!rst_n)
      linkEdge && haveHalf_q && half_shift_detect(blk) |=> !wr_q.en && haveHalf_q)
      else $error("misaligned block was written");
   a_header_row : assert property (@(posedge clk_sys) disable iff (!rst_n)
      linkEdge && haveHalf_q && !half_shift_detect(blk) && header_detect(blk)
      |=> wr_q.en && wr_q.row == $past(blk[POS_LSB +: ROW_W]) && row_q == wr_q.row + 1'b1)
      else $error("header did not set write row");

endmodule

// *** mcr_envelope_receive.sv ***
// Multichannel envelope receive path: per-channel receive, envelope buffer, output to MACs.
// Assumes link and transmit clocks arrive as pins much slower than clk_sys.
// Output ticks less than nine system cycles apart are ignored while a burst of octets is still going out.
module mcr_envelope_receive
   import mcr_pkg::*;
(
   input  wire logic                 clk_sys,
   input  wire logic                 arst_n,
   input  wire logic [NUM_COLS-1:0]  linkClk,
   input  wire mcr_xfer_t [NUM_COLS-1:0] linkXfer,
   input  wire logic [NUM_COLS-1:0]  colActive,
   input  wire logic                 txClk,
   output mcr_mac_t                  macOut_q,
   output logic [NUM_COLS-1:0]       envStart_q
);

   typedef enum logic {ST_WAIT, ST_SEND} mcr_state_t;

   logic [1:0]           rstSync_q;
   logic                 rst_n;
   logic [2:0]           txSync_q;
   logic [NUM_COLS-1:0]  actS1_q, actS2_q;
   logic                 outTick;
   mcr_wr_t              wr      [NUM_COLS];
   logic [TAG_W-1:0]     chanTag [NUM_COLS];
   logic [NUM_COLS-1:0]  chanTagValid;
   mcr_blk_t             cell_q  [NUM_COLS][NUM_ROWS];
   logic [NUM_ROWS-1:0]  full_q  [NUM_COLS];
   logic [COL_W-1:0]     rdCol_q;
   logic [ROW_W-1:0]     rdRow_q;
   mcr_state_t           state_q;
   mcr_blk_t             hold_q;
   logic [TAG_W-1:0]     holdTag_q;
   logic [OCT_W-1:0]     octIdx_q;
   logic                 take;
   logic                 skip;
   logic [7:0]           octData;
   logic                 octValid;

   // Reset release through two flops; assertion is immediate
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) rstSync_q <= '0;
      else rstSync_q <= {rstSync_q[0], 1'b1};
   end
   assign rst_n = rstSync_q[1];

   // Transmit clock and column enables are pins, so both are synchronised
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         txSync_q <= '0;
         actS1_q  <= '0;
         actS2_q  <= '0;
      end else begin
         txSync_q <= {txSync_q[1:0], txClk};
         actS1_q  <= colActive;
         actS2_q  <= actS1_q;
      end
   end

   // Rising edges only, so the tick runs at half the transmit edge rate
   assign outTick = txSync_q[1] & ~txSync_q[2];

   // Independent receive process per channel, each on its own sampled clock
   for (genvar c = 0; c < NUM_COLS; c++) begin : g_chan
      mcr_rx_channel u_rx (
         .clk_sys    (clk_sys),
         .rst_n      (rst_n),
         .linkClk    (linkClk[c]),
         .linkXfer   (linkXfer[c]),
         .wr_q       (wr[c]),
         .tag_q      (chanTag[c]),
         .tagValid_q (chanTagValid[c])
      );
   end

   // Read selection: take a filled cell, or skip a column whose next write lands
   // elsewhere after a header jump so a single bad marker cannot stall the reader
   assign take = full_q[rdCol_q][rdRow_q] && actS2_q[rdCol_q] && chanTagValid[rdCol_q];
   assign skip = !take && (!actS2_q[rdCol_q] || !chanTagValid[rdCol_q] ||
                           mcr_row_t'(wr[rdCol_q].row + 1'b1) != rdRow_q);

   // Envelope buffer storage, one column per channel
   for (genvar c = 0; c < NUM_COLS; c++) begin : g_col
      always_ff @(posedge clk_sys) begin
         if (wr[c].en) cell_q[c][wr[c].row] <= wr[c].blk;
      end

      // Fill flags keep the write ahead of the read; a set beats a same-cycle clear
      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            full_q[c] <= '0;
         end else begin
            for (int r = 0; r < NUM_ROWS; r++) begin
               if (wr[c].en && wr[c].row == ROW_W'(r)) full_q[c][r] <= 1'b1;
               else if (outTick && state_q == ST_WAIT && take &&
                        rdCol_q == COL_W'(c) && rdRow_q == ROW_W'(r))
                  full_q[c][r] <= 1'b0;
            end
         end
      end
   end

   // New-envelope pulses, one per channel
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         envStart_q <= '0;
      end else begin
         for (int c = 0; c < NUM_COLS; c++) envStart_q[c] <= wr[c].en & wr[c].envStart;
      end
   end

   // Read indices walk columns within a row, then rows, giving per-tag order
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdCol_q <= '0;
         rdRow_q <= '0;
      end else if (outTick && state_q == ST_WAIT && (take || skip)) begin
         rdCol_q <= rdCol_q + 1'b1;
         if (rdCol_q == COL_W'(NUM_COLS - 1)) rdRow_q <= rdRow_q + 1'b1;
      end
   end

   // Output sequencer: load one block, then shift its eight octets out
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q   <= ST_WAIT;
         hold_q    <= '0;
         holdTag_q <= '0;
         octIdx_q  <= '0;
      end else begin
         case (state_q)
            ST_WAIT: begin
               if (outTick && take) begin
                  hold_q    <= cell_q[rdCol_q][rdRow_q];
                  holdTag_q <= chanTag[rdCol_q];
                  octIdx_q  <= '0;
                  state_q   <= ST_SEND;
               end
            end
            ST_SEND: begin
               octIdx_q <= octIdx_q + 1'b1;
               if (octIdx_q == OCT_W'(OCT_N - 1)) state_q <= ST_WAIT;
            end
            default: state_q <= ST_WAIT;
         endcase
      end
   end

   // Octet translation towards the MAC
   always_comb begin
      octData  = blkData(hold_q, int'(octIdx_q));
      octValid = 1'b1;
      if (!blkCtrl(hold_q, int'(octIdx_q))) begin
         octValid = 1'b1;
      end else if (octData == CH_START) begin
         octData = CH_PREAMBLE;
      end else begin
         octData  = CH_IDLE;
         octValid = 1'b0;
      end
   end

   // Registered MAC outputs; idle and not valid between blocks
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         macOut_q <= '{strobe: 1'b0, valid: 1'b0, tag: '0, data: CH_IDLE};
      end else if (state_q == ST_SEND) begin
         macOut_q.strobe <= 1'b1;
         macOut_q.valid  <= octValid;
         macOut_q.data   <= octData;
         macOut_q.tag    <= holdTag_q;
      end else begin
         macOut_q.strobe <= 1'b0;
         macOut_q.valid  <= 1'b0;
         macOut_q.data   <= CH_IDLE;
      end
   end

   // Checks on the output path

   a_data_pass : assert property (@(posedge clk_sys) disable iff (!rst_n)
      state_q == ST_SEND && !blkCtrl(hold_q, int'(octIdx_q))
      |=> macOut_q.valid && macOut_q.data == $past(blkData(hold_q, int'(octIdx_q))))
      else $error("data octet not passed through");

   a_start_preamble : assert property (@(posedge clk_sys) disable iff (!rst_n)
      state_q == ST_SEND && blkCtrl(hold_q, int'(octIdx_q)) &&
      blkData(hold_q, int'(octIdx_q)) == CH_START
      |=> macOut_q.valid && macOut_q.data == CH_PREAMBLE)
      else $error("start character not replaced by preamble");

   a_ctrl_idle : assert property (@(posedge clk_sys) disable iff (!rst_n)
      state_q == ST_SEND && blkCtrl(hold_q, int'(octIdx_q)) &&
      blkData(hold_q, int'(octIdx_q)) != CH_START
      |=> !macOut_q.valid && macOut_q.data == CH_IDLE)
      else $error("control octet not turned into idle");

   a_octet_burst : assert property (@(posedge clk_sys) disable iff (!rst_n)
      state_q == ST_WAIT && outTick && take
      |=> ##1 macOut_q.strobe [*8] ##1 !macOut_q.strobe)
      else $error("block did not give eight octets");

   a_tag_route : assert property (@(posedge clk_sys) disable iff (!rst_n)
      state_q == ST_WAIT && outTick && take
      |=> ##1 macOut_q.tag == $past(chanTag[rdCol_q], 2))
      else $error("octets routed to wrong tag");

   a_tick_only : assert property (@(posedge clk_sys) disable iff (!rst_n)
      $changed(rdCol_q) |-> $past(outTick) && $past(state_q) == ST_WAIT)
      else $error("read index moved without a tick");

   a_row_advance : assert property (@(posedge clk_sys) disable iff (!rst_n)
      $changed(rdRow_q) |-> $past(rdCol_q) == COL_W'(NUM_COLS - 1) &&
                            rdRow_q == $past(rdRow_q) + 1'b1)
      else $error("read row moved out of order");

   a_write_ahead : assert property (@(posedge clk_sys) disable iff (!rst_n)
      state_q == ST_WAIT && outTick && take |=> !full_q[$past(rdCol_q)][$past(rdRow_q)] ||
                                              $past(wr[rdCol_q].en))
      else $error("read cell left marked full");

   a_quiet_between : assert property (@(posedge clk_sys) disable iff (!rst_n)
      $past(state_q) == ST_WAIT && state_q == ST_WAIT
      |=> !macOut_q.strobe && !macOut_q.valid && macOut_q.data == CH_IDLE)
      else $error("octet driven outside a block");

   c_block_sent : cover property (@(posedge clk_sys) disable iff (!rst_n)
      state_q == ST_WAIT && outTick && take);
   c_column_skip : cover property (@(posedge clk_sys) disable iff (!rst_n)
      state_q == ST_WAIT && outTick && skip && actS2_q[rdCol_q]);
   c_preamble_out : cover property (@(posedge clk_sys) disable iff (!rst_n)
      macOut_q.strobe && macOut_q.data == CH_PREAMBLE);
   c_env_start : cover property (@(posedge clk_sys) disable iff (!rst_n)
      |envStart_q);

endmodule

// *** mcr_pcs_model.sv ***
// Link-side model of one receive channel: clock edge per transfer, both edges.
// Assumes the bench fills seq and len while run is low.
module mcr_pcs_model
   import mcr_pkg::*;
#(
   parameter int PHASE = 0
)(
   input  wire logic       run,
   input  wire mcr_xfer_t  seq [32],
   input  wire logic [5:0] len,
   output mcr_xfer_t       linkXfer,
   output logic            linkClk
);
   timeunit 1ns;
   timeprecision 100ps;

   localparam mcr_xfer_t IDLE_X = '{data: 32'h07070707, ctrl: 4'hF};
   int idx;

   // Data turns 30 ns after an edge, well past the receiver's sampling delay
   initial begin
      linkClk = 1'b0;
      linkXfer = IDLE_X;
      forever begin
         wait (run);
         #(PHASE);
         idx = 0;
         while (run) begin
            linkXfer = (idx < len) ? seq[idx] : IDLE_X;
            idx++;
            #10 linkClk = ~linkClk;
            #30;
         end
         // Stopped link: invert so stale data never passes for fresh; clock parks low
         // so no false edge is seen when the receiver leaves reset
         linkXfer = ~linkXfer;
         linkClk = 1'b0;
      end
   end
endmodule

// *** tb_top.sv ***
// Self-checking bench for the multichannel envelope receive path.
// Assumes four link models on unrelated phases and a gated transmit clock pin.
module tb_top
   import mcr_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   localparam mcr_xfer_t IDLE_X = '{data: 32'h07070707, ctrl: 4'hF};
   localparam mcr_xfer_t SHIFT_X = '{data: 32'h08080808, ctrl: 4'hF};

   logic                           clkSys;
   logic                           arstN;
   logic [NUM_COLS-1:0]            colActive;
   logic                           txClk;
   logic                           run;
   logic                           txRun;
   wire  [NUM_COLS-1:0]            linkClk;
   wire  mcr_xfer_t [NUM_COLS-1:0] linkXfer;
   mcr_mac_t                       macOut;
   logic [NUM_COLS-1:0]            envStart;
   mcr_xfer_t                      chSeq [NUM_COLS][32];
   logic [5:0]                     chLen [NUM_COLS];
   logic [TAG_W-1:0]               tags [NUM_COLS];
   int                             starts [NUM_COLS];
   logic [23:0]                    expQ [$];
   logic [31:0]                    seed = 32'h6291;
   int                             nErrors = 0;
   int                             totalChecks = 0;

   // System clock, 8 ns
   initial begin
      clkSys = 1'b0;
      forever #4 clkSys = ~clkSys;
   end

   // Transmit pin held low between tests so the reader keeps its place
   initial begin
      txClk = 1'b0;
      forever #24 txClk = txRun & ~txClk;
   end

   for (genvar c = 0; c < NUM_COLS; c++) begin : g_link
      mcr_pcs_model #(
         .PHASE (7 * c)
      ) i_mcr_pcs_model (
         .run      (run & colActive[c]),
         .seq      (chSeq[c]),
         .len      (chLen[c]),
         .linkXfer (linkXfer[c]),
         .linkClk  (linkClk[c])
      );
   end

   mcr_envelope_receive i_mcr_envelope_receive (
      .clk_sys    (clkSys),
      .arst_n     (arstN),
      .linkClk    (linkClk),
      .linkXfer   (linkXfer),
      .colActive  (colActive),
      .txClk      (txClk),
      .macOut_q   (macOut),
      .envStart_q (envStart)
   );

   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      totalChecks++;
      if (got !== exp) begin
         nErrors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic conclude();
      $display("Checks %0d, mismatches %0d", totalChecks, nErrors);
      if (nErrors == 0 && totalChecks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic doReset();
      @(posedge clkSys);
      #1 arstN = 1'b0;
      run = 1'b0;
      txRun = 1'b0;
      expQ.delete();
      repeat (5) @(posedge clkSys);
      #1;
      check("reset output", 32'h7, 32'(macOut));
      check("reset start", 32'h0, 32'(envStart));
      arstN = 1'b1;
      repeat (3) @(posedge clkSys);
      #1;
   endtask

   task automatic putX(input int c, input mcr_xfer_t x);
      chSeq[c][chLen[c]] = x;
      chLen[c] = chLen[c] + 6'h1;
   endtask

   // Block i of channel c; block 0 is the header, later ones random data
   task automatic addBlock(input int c, input int i, input logic typ, input logic [5:0] mark);
      mcr_blk_t   b;
      logic [31:0] r;
      logic       cb;
      logic [7:0] d;
      b = 72'({rnd(), rnd(), rnd()});
      r = rnd();
      if (i == 0) begin
         b[3:0] = 4'h1;
         b[11:4] = 8'hFB;
         b[39:36] = 4'h0;
         b[16] = typ;
         b[45:40] = mark;
         b[63:48] = tags[c];
         for (int k = 0; k < 8; k++) expQ.push_back({tags[c], (k == 7) ? 8'hD5 : 8'h55});
      end else begin
         // Octets 0 and 4 stay data: no header or half-shift signature by accident
         b[0] = 1'b0;
         b[36] = 1'b0;
         b[47] = 1'b0;
         for (int k = 1; k < 8; k++) begin
            cb = (k < 4) ? b[k] : b[32+k];
            d = (r[2*k+:2] == 2'h0) ? 8'hFB : (r[2*k] ? 8'hFD : 8'h07);
            if (cb && k < 4) b[4+8*k+:8] = d;
            if (cb && k > 4) b[8+8*k+:8] = d;
         end
         for (int k = 0; k < 8; k++) begin
            cb = (k < 4) ? b[k] : b[32+k];
            d = (k < 4) ? b[4+8*k+:8] : b[8+8*k+:8];
            if (!cb) expQ.push_back({tags[c], d});
            else if (d == 8'hFB) expQ.push_back({tags[c], 8'h55});
         end
      end
      putX(c, b[35:0]);
      putX(c, b[71:36]);
   endtask

   task automatic runTest(input string nm, input logic [3:0] act, input logic typ,
                          input logic [5:0] mark, input int nBlk, input logic shifted);
      doReset();
      colActive = act;
      for (int c = 0; c < NUM_COLS; c++) begin
         chLen[c] = 6'h0;
         starts[c] = 0;
         tags[c] = 16'(rnd());
         if (shifted) begin
            putX(c, IDLE_X);
            putX(c, SHIFT_X);
            putX(c, IDLE_X);
         end
      end
      // Notes go in row order, columns left to right within a row
      for (int i = 0; i <= nBlk; i++) begin
         for (int c = 0; c < NUM_COLS; c++) begin
            if (act[c]) addBlock(c, i, typ, mark);
         end
      end
      run = 1'b1;
      repeat (shifted ? 45 : 30) @(posedge clkSys);
      #1 txRun = 1'b1;
      for (int w = 0; w < 4000 && expQ.size() != 0; w++) @(posedge clkSys);
      check("notes left", 32'h0, 32'(expQ.size()));
      for (int c = 0; c < NUM_COLS; c++) begin
         check("start pulses", 32'(typ & act[c]), 32'(starts[c]));
      end
      $display("Test %s done", nm);
   endtask

   // Every strobed octet is an idle or the oldest note; sampled mid-cycle when settled
   always @(negedge clkSys) begin
      if (macOut.strobe === 1'b1) begin
         if (macOut.valid !== 1'b1) begin
            check("idle octet", 32'h7, 32'(macOut.data));
         end else if (expQ.size() == 0) begin
            nErrors++;
            $display("MISMATCH octet expected none seen %h", macOut.data);
         end else begin
            check("octet", 32'(expQ.pop_front()), 32'({macOut.tag, macOut.data}));
         end
      end
   end

   // Envelope start pulses per channel
   always @(negedge clkSys) begin
      for (int c = 0; c < NUM_COLS; c++) begin
         if (envStart[c] === 1'b1) starts[c]++;
      end
   end

   // Four tests need well under 20 us; this only cuts a hang short
   initial begin
      #200000;
      nErrors++;
      $display("MISMATCH watchdog expected finish seen timeout");
      conclude();
   end

   initial begin
      arstN = 1'b0;
      colActive = 4'h0;
      run = 1'b0;
      txRun = 1'b0;
      runTest("start_single", 4'h1, 1'b1, 6'h0, 5, 1'b0);
      runTest("cont_shifted", 4'h1, 1'b0, 6'h3, 3, 1'b1);
      runTest("four_channels", 4'hF, 1'b1, 6'h1, 3, 1'b0);
      runTest("two_columns", 4'h5, 1'b0, 6'h2, 3, 1'b1);
      conclude();
   end
endmodule
